// >>> rtl/pd_watchdog.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - after reset the watchdog is off, timeout reads zero ms
// - timeout zero disables the watchdog; no expiry can occur
// - first output write starts timing; each later write restarts it
// - reads never retrigger the watchdog
// - expiry forces substitute outputs, sets status bit 1, net red
// - watchdog or connection timeout blocks output path to substitutes
// - output writes keep being stored during fail
// - clearing fail puts the latest stored data on outputs
// - once enabled the watchdog cannot be stopped
// - after a watchdog fail outputs return only after acknowledge
// - acknowledge restarts the watchdog count
// - auto mode: next output write clears fail, net goes green
// - manual mode: only the acknowledge command clears fail
// - net indicator shows connection, address and fail states
// - ready indicator: operational, update, invalid switch, not ready
// - per port link and activity indicators
// - per channel indicator: yellow when set, red on output fault
// - fault mode 0 all low, 1 all high, 2 hold last
// - fail reason 000c for watchdog, 000d for connection timeout
// - command word: one bit only; 0010 forces fail, 0020 acks
module pd_watchdog
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // register port
  input  wire logic [13:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output var  logic [15:0] O_RDATA,
  // device state from pins
  input  wire logic [15:0] I_IO_IN,
  input  wire logic [15:0] I_IO_FAULT,
  input  wire logic [15:0] I_IO_IS_OUT,
  input  wire logic [1:0]  I_LINK_UP,
  input  wire logic [1:0]  I_PORT_ACTIVE,
  input  wire logic        I_CONN_TIMEOUT,
  input  wire logic        I_CONN_POSSIBLE,
  input  wire logic        I_CONN_OPEN,
  input  wire logic        I_ADDR_REQUEST,
  input  wire logic        I_ADDR_INVALID,
  input  wire logic        I_ADDR_CONFLICT,
  input  wire logic        I_READY,
  input  wire logic        I_FW_UPDATE,
  input  wire logic        I_SWITCH_INVALID,
  // outputs and indicators
  output var  logic [15:0] O_IO_OUT,
  output var  logic [1:0]  O_LINK_INDICATOR,
  output var  logic [1:0]  O_ACTIVITY_INDICATOR,
  output var  logic [1:0]  O_READY_COLOR,
  output var  logic [1:0]  O_NET_COLOR,
  output var  logic [15:0] O_CH_YELLOW,
  output var  logic [15:0] O_CH_RED,
  output var  logic        O_FAIL
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 16 + 16 + 16 + 2 + 2 + 10;

  logic [NS-1:0] pins_q;
  logic [15:0]   io_in;
  logic [15:0]   io_fault;
  logic [15:0]   io_is_out;
  logic [1:0]    link_up;
  logic [1:0]    port_active;
  logic          conn_timeout;
  logic          conn_possible;
  logic          conn_open;
  logic          addr_request;
  logic          addr_invalid;
  logic          addr_conflict;
  logic          dev_ready;
  logic          fw_update;
  logic          switch_invalid;
  logic          tick;
  logic          flash;

  sync2 #(.W(NS)) u_sync
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_d     ({I_IO_IN, I_IO_FAULT, I_IO_IS_OUT, I_LINK_UP, I_PORT_ACTIVE,
               I_CONN_TIMEOUT, I_CONN_POSSIBLE, I_CONN_OPEN, I_ADDR_REQUEST,
               I_ADDR_INVALID, I_ADDR_CONFLICT, I_READY, I_FW_UPDATE,
               I_SWITCH_INVALID, 1'b0}),
    .o_q     (pins_q)
  );

  assign {io_in, io_fault, io_is_out, link_up, port_active, conn_timeout,
          conn_possible, conn_open, addr_request, addr_invalid,
          addr_conflict, dev_ready, fw_update, switch_invalid} =
         pins_q[NS-1:1];

  ms_tick u_tick
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .o_tick  (tick),
    .o_flash (flash)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [15:0] wd_timeout;
  logic [15:0] fault_mode;
  logic [15:0] fail_reason;
  logic [15:0] out_data;
  logic [15:0] held_out;
  logic        manual_ack;
  logic        cmd_error;
  logic        fail;
  logic        wd_armed;
  logic [15:0] wd_count;
  logic        wr_out;
  logic        wr_cmd;
  logic        cmd_onehot;
  logic        cmd_set;
  logic        cmd_ack;
  logic        wd_expire;
  logic        conn_edge;
  logic        conn_prev;
  logic        clear_fail;

  assign wr_out     = I_WR && (I_ADDR == pdw_pkg::ADDR_OUTPUT_DATA);
  assign wr_cmd     = I_WR && (I_ADDR == pdw_pkg::ADDR_COMMAND);
  assign cmd_onehot = (I_WDATA != 16'h0) && ((I_WDATA & (I_WDATA - 16'h1))
                      == 16'h0);
  assign cmd_set    = wr_cmd && (I_WDATA == pdw_pkg::CMD_SET_FAIL);
  assign cmd_ack    = wr_cmd && (I_WDATA == pdw_pkg::CMD_ACK_FAIL);
  assign conn_edge  = conn_timeout && !conn_prev;
  // manual mode needs the command; auto mode any output write
  assign clear_fail = fail && (manual_ack ? cmd_ack
                                          : (wr_out || cmd_ack));
  // timeout zero never expires
  assign wd_expire  = wd_armed && (wd_timeout != 16'h0) && tick
                      && (wd_count + 16'h1 >= wd_timeout);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      wd_timeout <= pdw_pkg::WD_TIMEOUT_RESET;
      fault_mode <= pdw_pkg::MODE_RESET;
      manual_ack <= 1'b0;
    end
    else if (I_WR)
    begin
      // once running, zero is refused so the watchdog cannot be stopped
      if (I_ADDR == pdw_pkg::ADDR_WD_TIMEOUT &&
          !(wd_timeout != 16'h0 && I_WDATA == 16'h0))
        wd_timeout <= I_WDATA;
      if (I_ADDR == pdw_pkg::ADDR_FAULT_MODE &&
          I_WDATA <= pdw_pkg::MODE_HOLD_LAST)
        fault_mode <= I_WDATA;
      if (I_ADDR == pdw_pkg::ADDR_CONFIG)
        manual_ack <= I_WDATA[pdw_pkg::CONFIG_MANUAL_BIT];
    end
  end

  // output data is stored always, even in fail
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      out_data <= 16'h0;
    else if (wr_out)
      out_data <= I_WDATA;
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      wd_armed <= 1'b0;
      wd_count <= 16'h0;
    end
    else if (wr_out || clear_fail)
    begin
      // only writes and acks retrigger; reads are not looked at
      wd_armed <= 1'b1;
      wd_count <= 16'h0;
    end
    else if (wd_expire)
    begin
      wd_armed <= 1'b0;
      wd_count <= 16'h0;
    end
    else if (wd_armed && tick && !fail)
      wd_count <= wd_count + 16'h1;
  end

  // ----------------------------------------------------------------
  // fail state; a new cause in the clear cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      fail        <= 1'b0;
      fail_reason <= pdw_pkg::REASON_NONE;
      held_out    <= 16'h0;
      conn_prev   <= 1'b0;
      cmd_error   <= 1'b0;
    end
    else
    begin
      conn_prev <= conn_timeout;
      if (wr_cmd)
        cmd_error <= !cmd_onehot;
      if (wd_expire || conn_edge || cmd_set)
      begin
        if (!fail)
          held_out <= O_IO_OUT;
        fail <= 1'b1;
        fail_reason <= wd_expire ? pdw_pkg::REASON_WATCHDOG
                     : conn_edge ? pdw_pkg::REASON_MODBUS
                     : pdw_pkg::REASON_USER;
      end
      else if (clear_fail)
        fail <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // physical outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      O_IO_OUT <= 16'h0;
    else if (fail)
      case (fault_mode)
        pdw_pkg::MODE_ALL_HIGH:  O_IO_OUT <= 16'hffff;
        pdw_pkg::MODE_HOLD_LAST: O_IO_OUT <= held_out;
        default:                 O_IO_OUT <= 16'h0;
      endcase
    else
      O_IO_OUT <= out_data;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      O_FAIL <= 1'b0;
    else
      O_FAIL <= fail;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      O_RDATA <= 16'h0;
    else if (I_RD)
      case (I_ADDR)
        pdw_pkg::ADDR_WD_TIMEOUT:  O_RDATA <= wd_timeout;
        pdw_pkg::ADDR_FAULT_MODE:  O_RDATA <= fault_mode;
        pdw_pkg::ADDR_FAIL_REASON: O_RDATA <= fail_reason;
        pdw_pkg::ADDR_STATUS:
          O_RDATA <= 16'((fail << pdw_pkg::STATUS_FAIL_BIT)
                       | (cmd_error << pdw_pkg::STATUS_CMDERR_BIT));
        pdw_pkg::ADDR_CONFIG:
          O_RDATA <= 16'(manual_ack << pdw_pkg::CONFIG_MANUAL_BIT);
        pdw_pkg::ADDR_INPUT_DATA:  O_RDATA <= io_in;
        pdw_pkg::ADDR_OUTPUT_DATA: O_RDATA <= out_data;
        default:                   O_RDATA <= 16'h0;
      endcase
    else
      O_RDATA <= 16'h0;
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      O_NET_COLOR   <= pdw_pkg::LED_OFF;
      O_READY_COLOR <= pdw_pkg::LED_OFF;
    end
    else
    begin
      // fail outranks all address and connection states
      if (!dev_ready)
        O_NET_COLOR <= pdw_pkg::LED_OFF;
      else if (fail)
        O_NET_COLOR <= pdw_pkg::LED_RED;
      else if (addr_conflict)
        O_NET_COLOR <= flash ? pdw_pkg::LED_RED : pdw_pkg::LED_OFF;
      else if (addr_invalid)
        O_NET_COLOR <= pdw_pkg::LED_YELLOW;
      else if (addr_request)
        O_NET_COLOR <= flash ? pdw_pkg::LED_YELLOW : pdw_pkg::LED_OFF;
      else if (conn_open)
        O_NET_COLOR <= pdw_pkg::LED_GREEN;
      else if (conn_possible)
        O_NET_COLOR <= flash ? pdw_pkg::LED_GREEN : pdw_pkg::LED_OFF;
      else
        O_NET_COLOR <= pdw_pkg::LED_OFF;
      if (switch_invalid)
        O_READY_COLOR <= pdw_pkg::LED_RED;
      else if (!dev_ready)
        O_READY_COLOR <= pdw_pkg::LED_OFF;
      else if (fw_update)
        O_READY_COLOR <= flash ? pdw_pkg::LED_GREEN : pdw_pkg::LED_OFF;
      else
        O_READY_COLOR <= pdw_pkg::LED_GREEN;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      O_LINK_INDICATOR     <= 2'h0;
      O_ACTIVITY_INDICATOR <= 2'h0;
    end
    else
    begin
      O_LINK_INDICATOR     <= link_up;
      O_ACTIVITY_INDICATOR <= port_active;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 16; ch++)
    begin : g_ch
      always_ff @(posedge I_CLK_SYS)
      begin
        if (!I_RST_N)
        begin
          O_CH_YELLOW[ch] <= 1'b0;
          O_CH_RED[ch]    <= 1'b0;
        end
        else
        begin
          O_CH_RED[ch]    <= io_is_out[ch] && io_fault[ch];
          O_CH_YELLOW[ch] <= !(io_is_out[ch] && io_fault[ch]) &&
                             (io_is_out[ch] ? O_IO_OUT[ch] : io_in[ch]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/pdw_pkg.sv
package pdw_pkg;

  // ----------------------------------------------------------------
  // register indices (word addresses on the register port)
  // ----------------------------------------------------------------
  localparam logic [13:0] ADDR_MODBUS_TIMEOUT = 14'd1280;
  localparam logic [13:0] ADDR_WD_TIMEOUT     = 14'd2000;
  localparam logic [13:0] ADDR_FAULT_MODE     = 14'd2002;
  localparam logic [13:0] ADDR_FAIL_REASON    = 14'd2004;
  localparam logic [13:0] ADDR_COMMAND        = 14'd2006;
  localparam logic [13:0] ADDR_STATUS         = 14'd7996;
  localparam logic [13:0] ADDR_CONFIG         = 14'd7990;
  localparam logic [13:0] ADDR_INPUT_DATA     = 14'd8000;
  localparam logic [13:0] ADDR_OUTPUT_DATA    = 14'd9000;

  // ----------------------------------------------------------------
  // field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int          STATUS_FAIL_BIT   = 1;
  localparam int          STATUS_CMDERR_BIT = 2;
  localparam int          CONFIG_MANUAL_BIT = 0;
  localparam logic [15:0] WD_TIMEOUT_RESET  = 16'h0000;
  localparam logic [15:0] MODE_ALL_LOW      = 16'h0000;
  localparam logic [15:0] MODE_ALL_HIGH     = 16'h0001;
  localparam logic [15:0] MODE_HOLD_LAST    = 16'h0002;
  localparam logic [15:0] MODE_RESET        = 16'h0000;
  localparam logic [15:0] REASON_NONE       = 16'h0000;
  localparam logic [15:0] REASON_WATCHDOG   = 16'h000c;
  localparam logic [15:0] REASON_MODBUS     = 16'h000d;
  localparam logic [15:0] REASON_USER       = 16'h0009;
  localparam logic [15:0] CMD_SET_FAIL      = 16'h0010;
  localparam logic [15:0] CMD_ACK_FAIL      = 16'h0020;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int FLASH_MS      = 500;
  localparam int FLASH_TICKS   = FLASH_MS / TICK_MS;

  // ----------------------------------------------------------------
  // indicator encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_YELLOW, LED_RED} color_t;

endpackage

// >>> rtl/ms_tick.sv
`timescale 1ns/1ps
`default_nettype none
module ms_tick
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // tick out
  output var  logic o_tick,
  output var  logic o_flash
);

  localparam logic [13:0] TICK_LAST = 14'(pdw_pkg::TICK_CYCLES - 1);
  localparam logic [9:0]  FLASH_LAST = 10'(pdw_pkg::FLASH_TICKS - 1);

  logic [13:0] div;
  logic [9:0]  fdiv;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      div    <= 14'h0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= (div == TICK_LAST);
      div    <= (div == TICK_LAST) ? 14'h0 : div + 14'h1;
    end
  end

  // flash phase toggles every half period
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fdiv    <= 10'h0;
      o_flash <= 1'b0;
    end
    else if (o_tick)
    begin
      fdiv <= (fdiv == FLASH_LAST) ? 10'h0 : fdiv + 10'h1;
      if (fdiv == FLASH_LAST)
        o_flash <= ~o_flash;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // data
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> tb/pd_watchdog_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pd_watchdog_monitor
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // register port
  input  wire logic [13:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [15:0] O_RDATA,
  // pin state
  input  wire logic [15:0] I_IO_IN,
  input  wire logic [15:0] I_IO_IS_OUT,
  input  wire logic [1:0]  I_LINK_UP,
  input  wire logic [1:0]  I_PORT_ACTIVE,
  input  wire logic        I_CONN_TIMEOUT,
  input  wire logic        I_READY,
  input  wire logic        I_FW_UPDATE,
  input  wire logic        I_SWITCH_INVALID,
  // outputs and indicators
  input  wire logic [15:0] O_IO_OUT,
  input  wire logic [1:0]  O_LINK_INDICATOR,
  input  wire logic [1:0]  O_ACTIVITY_INDICATOR,
  input  wire logic [1:0]  O_READY_COLOR,
  input  wire logic [1:0]  O_NET_COLOR,
  input  wire logic [15:0] O_CH_YELLOW,
  input  wire logic        O_FAIL
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  property p_rst;
    $rose(I_RST_N) |-> !O_FAIL && O_IO_OUT == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear");

  property p_red;
    $rose(O_FAIL) |-> ##1 O_NET_COLOR == pdw_pkg::LED_RED;
  endproperty
  a_red: assert property (p_red) else $error("net not red");

  property p_hold_red;
    O_FAIL && $past(O_FAIL) |-> O_NET_COLOR == pdw_pkg::LED_RED;
  endproperty
  a_hold_red: assert property (p_hold_red) else $error("red lost");

  property p_stat;
    I_RD && I_ADDR == pdw_pkg::ADDR_STATUS |=> O_RDATA[1] == O_FAIL;
  endproperty
  a_stat: assert property (p_stat) else $error("status bit wrong");

  property p_conn;
    $rose(I_CONN_TIMEOUT) |-> ##[1:6] O_FAIL;
  endproperty
  a_conn: assert property (p_conn) else $error("no fail on conn");

  property p_cmd;
    I_WR && I_ADDR == pdw_pkg::ADDR_COMMAND
      && I_WDATA == pdw_pkg::CMD_SET_FAIL |-> ##[1:3] O_FAIL;
  endproperty
  a_cmd: assert property (p_cmd) else $error("forced fail lost");

  property p_link;
    $stable({I_LINK_UP, I_PORT_ACTIVE}) [*5]
      |-> {O_LINK_INDICATOR, O_ACTIVITY_INDICATOR}
          == {I_LINK_UP, I_PORT_ACTIVE};
  endproperty
  a_link: assert property (p_link) else $error("port leds wrong");

  property p_chan;
    $stable({I_IO_IN, I_IO_IS_OUT}) [*5]
      |-> (O_CH_YELLOW & ~I_IO_IS_OUT) == (I_IO_IN & ~I_IO_IS_OUT);
  endproperty
  a_chan: assert property (p_chan) else $error("channel led wrong");

  property p_rdy;
    ($stable({I_READY, I_FW_UPDATE, I_SWITCH_INVALID}) && I_READY
      && !I_FW_UPDATE && !I_SWITCH_INVALID) [*5]
      |-> O_READY_COLOR == pdw_pkg::LED_GREEN;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not green");
endmodule

bind pd_watchdog pd_watchdog_monitor u_mon (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_IO_IN(I_IO_IN), .I_IO_IS_OUT(I_IO_IS_OUT), .I_LINK_UP(I_LINK_UP),
  .I_PORT_ACTIVE(I_PORT_ACTIVE), .I_CONN_TIMEOUT(I_CONN_TIMEOUT),
  .I_READY(I_READY), .I_FW_UPDATE(I_FW_UPDATE),
  .I_SWITCH_INVALID(I_SWITCH_INVALID), .O_IO_OUT(O_IO_OUT),
  .O_LINK_INDICATOR(O_LINK_INDICATOR),
  .O_ACTIVITY_INDICATOR(O_ACTIVITY_INDICATOR),
  .O_READY_COLOR(O_READY_COLOR), .O_NET_COLOR(O_NET_COLOR),
  .O_CH_YELLOW(O_CH_YELLOW), .O_FAIL(O_FAIL)
);
`default_nettype wire

// >>> tb/net_client.sv
`timescale 1ns/1ps
`default_nettype none
module net_client
(
  // clock
  input  wire logic        i_clk,
  // register port toward the device
  output var  logic [13:0] o_addr,
  output var  logic [15:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  initial
  begin
    o_addr  = 14'h0000;
    o_wdata = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [13:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
  endtask

  // short timeout keeps the run brief; zero is refused once the watchdog runs
  task automatic set_timeout(input logic [15:0] ms);
    wr(pdw_pkg::ADDR_WD_TIMEOUT, ms);
  endtask

  // one bit per command; ack is the only exit from a manual fail
  task automatic command(input logic [15:0] c);
    wr(pdw_pkg::ADDR_COMMAND, c);
  endtask
endmodule
`default_nettype wire

// >>> tb/process_data_watchdog_netfail_bench.sv
`timescale 1ns/1ps
`default_nettype none
module process_data_watchdog_netfail_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] io_in = 16'h0000;
  logic [15:0] io_flt = 16'h0000;
  logic [15:0] io_dir = 16'h0000;
  logic        conn_pos = 1'b0;
  logic [15:0] ch_red;
  logic [1:0]  link = 2'h0;
  logic [1:0]  act = 2'h0;
  logic        conn_to = 1'b0;
  logic        conn_open = 1'b0;
  logic        ready = 1'b0;
  logic        fw = 1'b0;
  logic        sw_bad = 1'b0;
  logic [15:0] io_out;
  logic [15:0] ch_yel;
  logic [1:0]  link_ind;
  logic [1:0]  act_ind;
  logic [1:0]  rdy_col;
  logic [1:0]  net_col;
  logic        fail;
  logic [15:0] exp_q[$];
  logic        rd1 = 1'b0;
  int          failures = 0;
  int          n_tests = 0;
  int          n;

  always #50 clk = ~clk;

  net_client u_client (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  pd_watchdog DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_IO_IN(io_in), .I_IO_FAULT(io_flt), .I_IO_IS_OUT(io_dir),
    .I_LINK_UP(link), .I_PORT_ACTIVE(act), .I_CONN_TIMEOUT(conn_to),
    .I_CONN_POSSIBLE(conn_pos), .I_CONN_OPEN(conn_open),
    .I_ADDR_REQUEST(1'b0), .I_ADDR_INVALID(1'b0), .I_ADDR_CONFLICT(1'b0),
    .I_READY(ready), .I_FW_UPDATE(fw), .I_SWITCH_INVALID(sw_bad),
    .O_IO_OUT(io_out), .O_LINK_INDICATOR(link_ind),
    .O_ACTIVITY_INDICATOR(act_ind), .O_READY_COLOR(rdy_col),
    .O_NET_COLOR(net_col), .O_CH_YELLOW(ch_yel), .O_CH_RED(ch_red),
    .O_FAIL(fail));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [13:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    u_client.rd(a);
  endtask

  // read data stands only in the cycle after the read strobe
  always @(posedge clk)
    rd1 <= rd;
  always @(negedge clk)
    if (rd1 === 1'b1)
      check(rdata, exp_q.pop_front());

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // whole run plus margin
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h10e2cff1));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(pdw_pkg::ADDR_WD_TIMEOUT, pdw_pkg::WD_TIMEOUT_RESET);
    rd_chk(pdw_pkg::ADDR_STATUS, 16'h0000);
    rd_chk(14'h0064, 16'h0000);
    check(io_out, 16'h0000);
    io_in <= 16'($urandom);
    io_flt <= 16'($urandom);
    link <= 2'($urandom);
    act <= 2'($urandom);
    ready <= 1'b1;
    conn_open <= 1'b1;
    repeat (8) @(posedge clk);
    check({12'h0, link_ind, act_ind}, {12'h0, link, act});
    check(ch_yel, io_in);
    check({14'h0, rdy_col}, 16'h0001);
    check({14'h0, net_col}, 16'h0001);
    sw_bad <= 1'b1;
    repeat (8) @(posedge clk);
    check({14'h0, rdy_col}, 16'h0003);
    sw_bad <= 1'b0;
    // outputs are still low here, so output channels show no yellow
    io_dir <= 16'($urandom);
    conn_pos <= 1'b1;
    repeat (8) @(posedge clk);
    check(ch_red, io_dir & io_flt);
    check(ch_yel, io_in & ~io_dir);
    $display("indicator test done");
    u_client.wr(pdw_pkg::ADDR_OUTPUT_DATA, 16'h00a5);
    repeat (12000) @(posedge clk);
    check({15'h0, fail}, 16'h0000);
    check(io_out, 16'h00a5);
    $display("disabled test done");
    u_client.wr(pdw_pkg::ADDR_CONFIG, 16'h0001);
    u_client.wr(pdw_pkg::ADDR_FAULT_MODE, pdw_pkg::MODE_ALL_HIGH);
    u_client.set_timeout(16'h0002);
    u_client.wr(pdw_pkg::ADDR_OUTPUT_DATA, 16'h1234);
    n = 0;
    while (fail !== 1'b1 && n < 25)
    begin
      repeat (2000) @(posedge clk);
      rd_chk(pdw_pkg::ADDR_OUTPUT_DATA, 16'h1234);
      n++;
    end
    check({15'h0, fail}, 16'h0001);
    check({15'h0, n >= 4 && n <= 16}, 16'h0001);
    check(io_out, 16'hffff);
    check({14'h0, net_col}, 16'h0003);
    rd_chk(pdw_pkg::ADDR_STATUS, 16'h0002);
    rd_chk(pdw_pkg::ADDR_FAIL_REASON, pdw_pkg::REASON_WATCHDOG);
    u_client.wr(pdw_pkg::ADDR_OUTPUT_DATA, 16'h5a5a);
    repeat (5) @(posedge clk);
    check({15'h0, fail}, 16'h0001);
    check(io_out, 16'hffff);
    rd_chk(pdw_pkg::ADDR_OUTPUT_DATA, 16'h5a5a);
    u_client.set_timeout(16'h0000);
    rd_chk(pdw_pkg::ADDR_WD_TIMEOUT, 16'h0002);
    u_client.command(pdw_pkg::CMD_ACK_FAIL);
    repeat (5) @(posedge clk);
    check({15'h0, fail}, 16'h0000);
    check(io_out, 16'h5a5a);
    $display("expiry and manual ack test done");
    u_client.wr(pdw_pkg::ADDR_COMMAND, 16'h0030);
    rd_chk(pdw_pkg::ADDR_STATUS, 16'h0004);
    u_client.command(pdw_pkg::CMD_SET_FAIL);
    repeat (5) @(posedge clk);
    check({15'h0, fail}, 16'h0001);
    rd_chk(pdw_pkg::ADDR_FAIL_REASON, pdw_pkg::REASON_USER);
    rd_chk(pdw_pkg::ADDR_STATUS, 16'h0002);
    u_client.wr(pdw_pkg::ADDR_CONFIG, 16'h0000);
    u_client.wr(pdw_pkg::ADDR_OUTPUT_DATA, 16'h0f0f);
    repeat (5) @(posedge clk);
    check({15'h0, fail}, 16'h0000);
    check(io_out, 16'h0f0f);
    check({14'h0, net_col}, 16'h0001);
    $display("command and auto ack test done");
    u_client.wr(pdw_pkg::ADDR_FAULT_MODE, pdw_pkg::MODE_HOLD_LAST);
    n = 0;
    while (fail !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    check({15'h0, fail}, 16'h0001);
    check(io_out, 16'h0f0f);
    rd_chk(pdw_pkg::ADDR_FAIL_REASON, pdw_pkg::REASON_WATCHDOG);
    u_client.wr(pdw_pkg::ADDR_OUTPUT_DATA, 16'h3c3c);
    u_client.wr(pdw_pkg::ADDR_FAULT_MODE, pdw_pkg::MODE_ALL_LOW);
    u_client.wr(pdw_pkg::ADDR_FAULT_MODE, 16'h0003);
    rd_chk(pdw_pkg::ADDR_FAULT_MODE, pdw_pkg::MODE_ALL_LOW);
    check(io_out, 16'h3c3c);
    conn_to <= 1'b1;
    repeat (8) @(posedge clk);
    check({15'h0, fail}, 16'h0001);
    check(io_out, 16'h0000);
    rd_chk(pdw_pkg::ADDR_FAIL_REASON, pdw_pkg::REASON_MODBUS);
    conn_to <= 1'b0;
    repeat (4) @(posedge clk);
    $display("hold and connection test done");
    finish_test();
  end
endmodule
`default_nettype wire
